//--- core/ers_reg_mem.sv
`timescale 1ns/10ps
module ers_reg_mem #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 32,
    parameter int NRD   = 3,
    parameter int AW    = $clog2(DEPTH)
) (
    input  wire logic                       mclk,
    input  wire logic                       sys_rst,
    input  wire logic                       wrEn,
    input  wire logic [AW-1:0]              wrAddr,
    input  wire logic [WIDTH-1:0]           wrData,
    input  wire logic [NRD-1:0][AW-1:0]     rdAddr,
    output logic      [NRD-1:0][WIDTH-1:0]  rdData
);
    logic [DEPTH-1:0][WIDTH-1:0] mem_reg;
    logic [DEPTH-1:0][WIDTH-1:0] mem_next;
    logic [NRD-1:0][WIDTH-1:0]   rd_next;

    always_comb begin
        mem_next = mem_reg;
        if (wrEn) begin
            mem_next[wrAddr] = wrData;
        end
        for (int i = 0; i < NRD; i++) begin
            rd_next[i] = mem_reg[rdAddr[i]];
        end
    end

    // small enough to live in flops, so every word has a known reset value
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            mem_reg <= '0;
            rdData  <= '0;
        end else begin
            mem_reg <= mem_next;
            rdData  <= rd_next;
        end
    end
endmodule

//--- core/ers_rx_sig_sub.sv
// Design decision made here: the Wishbone interface to the registers.
`timescale 1ns/10ps
module ers_rx_sig_sub #(
    parameter int NUM_SLOTS = ers_pkg::ERS_NUM_SLOTS
) (
    input  wire logic                          mclk,
    input  wire logic                          sys_rst,
    input  wire logic                          wb_cyc_i,
    input  wire logic                          wb_stb_i,
    input  wire logic                          wb_we_i,
    input  wire logic [ers_pkg::ERS_ADR_W-1:0] wb_adr_i,
    input  wire logic [ers_pkg::ERS_SEL_W-1:0] wb_sel_i,
    input  wire logic [ers_pkg::ERS_WB_W-1:0]  wb_dat_i,
    output logic      [ers_pkg::ERS_WB_W-1:0]  wb_dat_o,
    output logic                               wb_ack_o,
    input  wire ers_pkg::ers_beat_type         condBeat,
    output ers_pkg::ers_beat_type              rxSerialOut
);
    import ers_pkg::*;

    localparam int AW = $clog2(NUM_SLOTS);

    function automatic logic [ERS_NIB_W-1:0] subNibble(
        input logic [ERS_DATA_W-1:0] ctrl,
        input logic [ERS_DATA_W-1:0] sub,
        input logic [ERS_NIB_W-1:0]  orig
    );
        ers_sub_mode_type mode;
        logic [ERS_NIB_W-1:0] res;
        mode = ers_sub_mode_type'(ctrl[ERS_CTRL_MODE_LSB +: 2]);
        res  = orig;
        if (ctrl[ERS_CTRL_SUB_EN_BIT]) begin
            unique case (mode)
                ERS_SUB_ALL_ONES: begin
                    res = '1;
                end
                ERS_SUB_TWO: begin
                    res = {ERS_NIB_W{sub[ERS_TWO_CODE_BIT]}};
                end
                ERS_SUB_FOUR: begin
                    res = {{2{sub[ERS_FOUR_A_BIT]}}, {2{sub[ERS_FOUR_B_BIT]}}};
                end
                ERS_SUB_SIXTEEN: begin
                    // bits 7-4 deliberately never looked at
                    res = sub[ERS_SIXTEEN_A:ERS_SIXTEEN_D];
                end
            endcase
        end
        return res;
    endfunction

    function automatic ers_hit_type decodeHit(input logic [7:0] idx);
        ers_hit_type hit;
        hit = ERS_HIT_NONE;
        if (idx[7:ERS_BANK_LSB] == ERS_SUB_BASE_IDX[7:ERS_BANK_LSB]) begin
            hit = ERS_HIT_SUB;
        end else if (idx[7:ERS_BANK_LSB] == ERS_CTRL_BASE_IDX[7:ERS_BANK_LSB]) begin
            hit = ERS_HIT_CTRL;
        end else if (idx == ERS_STAT_IDX) begin
            hit = ERS_HIT_STAT;
        end
        return hit;
    endfunction

    function automatic logic isCasBeat(input ers_beat_type b);
        return b.valid && (b.slot == ERS_CAS_SLOT) && (b.frame != ERS_MFAS_FRAME);
    endfunction

    // bus side state
    ers_bus_state_type      busState_reg;
    ers_bus_state_type      busState_next;
    logic [7:0]             busIdx_reg;
    logic [7:0]             busIdx_next;
    logic [ERS_WB_W-1:0]    datOut_reg;
    logic [ERS_WB_W-1:0]    datOut_next;
    logic                   ack_reg;
    logic                   ack_next;

    // stream side state
    ers_beat_type           beat1_reg;
    ers_beat_type           beat1_next;
    ers_beat_type           outBeat_reg;
    ers_beat_type           outBeat_next;
    logic [ERS_DATA_W-1:0]  lastSig_reg;
    logic [ERS_DATA_W-1:0]  lastSig_next;

    // register memories
    logic                          busStart;
    logic [7:0]                    reqIdx;
    ers_hit_type                   reqHit;
    logic                          subWrEn;
    logic                          ctrlWrEn;
    logic [ERS_NUM_RD-1:0][AW-1:0] rdAddr;
    logic [ERS_NUM_RD-1:0][ERS_DATA_W-1:0] subRd;
    logic [ERS_NUM_RD-1:0][ERS_DATA_W-1:0] ctrlRd;

    assign reqIdx   = wb_adr_i[ERS_ADR_W-1:2];
    assign reqHit   = decodeHit(reqIdx);
    assign busStart = wb_cyc_i && wb_stb_i && (busState_reg == ERS_BUS_IDLE) && !ack_reg;
    // writes land at the start edge; the status word is read-only
    assign subWrEn  = busStart && wb_we_i && wb_sel_i[0] && (reqHit == ERS_HIT_SUB);
    assign ctrlWrEn = busStart && wb_we_i && wb_sel_i[0] && (reqHit == ERS_HIT_CTRL);

    // port 0: channel in high nibble, port 1: channel 16 later, port 2: bus
    assign rdAddr[0] = {1'b0, condBeat.frame};
    assign rdAddr[1] = {1'b1, condBeat.frame};
    assign rdAddr[2] = reqIdx[AW-1:0];

    ers_reg_mem #(
        .WIDTH (ERS_DATA_W),
        .DEPTH (NUM_SLOTS),
        .NRD   (ERS_NUM_RD)
    ) subMem (
        .mclk    (mclk),
        .sys_rst (sys_rst),
        .wrEn    (subWrEn),
        .wrAddr  (reqIdx[AW-1:0]),
        .wrData  (wb_dat_i[ERS_DATA_W-1:0]),
        .rdAddr  (rdAddr),
        .rdData  (subRd)
    );

    ers_reg_mem #(
        .WIDTH (ERS_DATA_W),
        .DEPTH (NUM_SLOTS),
        .NRD   (ERS_NUM_RD)
    ) ctrlMem (
        .mclk    (mclk),
        .sys_rst (sys_rst),
        .wrEn    (ctrlWrEn),
        .wrAddr  (reqIdx[AW-1:0]),
        .wrData  (wb_dat_i[ERS_DATA_W-1:0]),
        .rdAddr  (rdAddr),
        .rdData  (ctrlRd)
    );

    // bus: idle -> fetch (memory read in flight) -> answer (ack for one cycle)
    always_comb begin
        busState_next = busState_reg;
        busIdx_next   = busIdx_reg;
        datOut_next   = datOut_reg;
        ack_next      = 1'b0;
        unique case (busState_reg)
            ERS_BUS_IDLE: begin
                if (busStart) begin
                    busIdx_next   = reqIdx;
                    busState_next = ERS_BUS_FETCH;
                end
            end
            ERS_BUS_FETCH: begin
                datOut_next = '0;
                unique case (decodeHit(busIdx_reg))
                    ERS_HIT_SUB: begin
                        datOut_next[ERS_DATA_W-1:0] = subRd[2];
                    end
                    ERS_HIT_CTRL: begin
                        datOut_next[ERS_DATA_W-1:0] = ctrlRd[2];
                    end
                    ERS_HIT_STAT: begin
                        datOut_next[ERS_DATA_W-1:0] = lastSig_reg;
                    end
                    ERS_HIT_NONE: begin
                        datOut_next = '0;
                    end
                endcase
                ack_next      = 1'b1;
                busState_next = ERS_BUS_ANSWER;
            end
            ERS_BUS_ANSWER: begin
                busState_next = ERS_BUS_IDLE;
            end
            default: begin
                busState_next = ERS_BUS_IDLE;
            end
        endcase
    end

    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            busState_reg <= ERS_BUS_IDLE;
            busIdx_reg   <= 8'h00;
            datOut_reg   <= '0;
            ack_reg      <= 1'b0;
        end else begin
            busState_reg <= busState_next;
            busIdx_reg   <= busIdx_next;
            datOut_reg   <= datOut_next;
            ack_reg      <= ack_next;
        end
    end

    assign wb_dat_o = datOut_reg;
    assign wb_ack_o = ack_reg;

    // stream: stage 1 waits on the per-channel lookup, stage 2 substitutes.
    // config written mid-frame takes effect from the next beat onward.
    always_comb begin
        beat1_next   = condBeat;
        outBeat_next = beat1_reg;
        lastSig_next = lastSig_reg;
        if (isCasBeat(beat1_reg)) begin
            // high nibble is the channel numbered by the frame, low the one 16 later
            outBeat_next.data = {
                subNibble(ctrlRd[0], subRd[0], beat1_reg.data[7:4]),
                subNibble(ctrlRd[1], subRd[1], beat1_reg.data[3:0])
            };
            lastSig_next = {beat1_reg.data[7:4], beat1_reg.frame};
        end
    end

    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            beat1_reg   <= '0;
            outBeat_reg <= '0;
            lastSig_reg <= ERS_REG_RESET;
        end else begin
            beat1_reg   <= beat1_next;
            outBeat_reg <= outBeat_next;
            lastSig_reg <= lastSig_next;
        end
    end

    assign rxSerialOut = outBeat_reg;
endmodule

//--- include/ers_pkg.sv
package ers_pkg;

    // stream geometry
    localparam int ERS_NUM_SLOTS = 32;
    localparam int ERS_SLOT_W    = 5;
    localparam int ERS_FRAME_W   = 4;
    localparam int ERS_DATA_W    = 8;
    localparam int ERS_NIB_W     = 4;
    localparam int ERS_NUM_RD    = 3;

    localparam logic [ERS_SLOT_W-1:0]  ERS_CAS_SLOT   = 5'h10;
    localparam logic [ERS_FRAME_W-1:0] ERS_MFAS_FRAME = 4'h0;

    // wishbone: register index n sits at byte address 4*n
    localparam int ERS_ADR_W = 10;
    localparam int ERS_WB_W  = 32;
    localparam int ERS_SEL_W = 4;
    localparam logic [7:0] ERS_SUB_BASE_IDX  = 8'h80;
    localparam logic [7:0] ERS_CTRL_BASE_IDX = 8'ha0;
    localparam logic [7:0] ERS_STAT_IDX      = 8'hc0;
    localparam int ERS_BANK_LSB = 5;

    localparam logic [ERS_DATA_W-1:0] ERS_REG_RESET = 8'h00;

    // control register fields
    localparam int ERS_CTRL_SUB_EN_BIT = 6;
    localparam int ERS_CTRL_MODE_LSB   = 2;

    // substitution register fields
    localparam int ERS_TWO_CODE_BIT = 3;
    localparam int ERS_FOUR_A_BIT   = 3;
    localparam int ERS_FOUR_B_BIT   = 2;
    localparam int ERS_SIXTEEN_A    = 3;
    localparam int ERS_SIXTEEN_D    = 0;

    // status register fields
    localparam int ERS_STAT_NIB_LSB = 4;

    typedef enum logic [1:0] {
        ERS_SUB_ALL_ONES = 2'b00,
        ERS_SUB_TWO      = 2'b01,
        ERS_SUB_FOUR     = 2'b10,
        ERS_SUB_SIXTEEN  = 2'b11
    } ers_sub_mode_type;

    typedef enum logic [1:0] {
        ERS_BUS_IDLE   = 2'b00,
        ERS_BUS_FETCH  = 2'b01,
        ERS_BUS_ANSWER = 2'b10
    } ers_bus_state_type;

    typedef enum logic [1:0] {
        ERS_HIT_NONE = 2'b00,
        ERS_HIT_SUB  = 2'b01,
        ERS_HIT_CTRL = 2'b10,
        ERS_HIT_STAT = 2'b11
    } ers_hit_type;

    typedef struct packed {
        logic                   valid;
        logic [ERS_FRAME_W-1:0] frame;
        logic [ERS_SLOT_W-1:0]  slot;
        logic [ERS_DATA_W-1:0]  data;
    } ers_beat_type;

endpackage

//--- test/ers_rx_sig_sub_props.sv
`timescale 1ns/10ps
module ers_rx_sig_sub_props #(
    parameter int NUM_SLOTS = 32
) (
    input wire logic                  mclk,
    input wire logic                  sys_rst,
    input wire logic                  wb_cyc_i,
    input wire logic                  wb_stb_i,
    input wire logic [31:0]           wb_dat_o,
    input wire logic                  wb_ack_o,
    input wire ers_pkg::ers_beat_type condBeat,
    input wire ers_pkg::ers_beat_type rxSerialOut
);
    import ers_pkg::*;
    default clocking @(posedge mclk); endclocking
    default disable iff (sys_rst);
    logic req;
    assign req = wb_cyc_i && wb_stb_i;

    beat_latency_a: assert property (
        rxSerialOut.valid == $past(condBeat.valid, 2))
        else $error("output beat not two cycles after input beat");
    beat_place_a: assert property (
        $past(condBeat.valid, 2) |-> rxSerialOut.slot == $past(condBeat.slot, 2)
        && rxSerialOut.frame == $past(condBeat.frame, 2))
        else $error("output beat frame or slot changed");
    other_slots_a: assert property (
        $past(condBeat.valid, 2) && $past(condBeat.slot, 2) != ERS_CAS_SLOT
        |-> rxSerialOut.data == $past(condBeat.data, 2))
        else $error("non signaling slot data altered");
    frame_zero_a: assert property (
        $past(condBeat.valid, 2) && $past(condBeat.slot, 2) == ERS_CAS_SLOT
        && $past(condBeat.frame, 2) == ERS_MFAS_FRAME
        |-> rxSerialOut.data == $past(condBeat.data, 2))
        else $error("multiframe alignment byte altered");
    ack_timing_a: assert property (
        $rose(req) |-> !wb_ack_o ##1 !wb_ack_o ##1 wb_ack_o)
        else $error("bus answer not in third cycle");
    ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack longer than one cycle");
    ack_cause_a: assert property (wb_ack_o |-> req && $past(req, 2))
        else $error("ack without a held request");
    read_upper_a: assert property (wb_ack_o |-> wb_dat_o[31:8] == 24'h0)
        else $error("read data above low byte not zero");

    cover property (wb_ack_o);
    cover property (rxSerialOut.valid && rxSerialOut.slot == ERS_CAS_SLOT);
    cover property (rxSerialOut.valid && rxSerialOut.frame == ERS_MFAS_FRAME);
endmodule

bind ers_rx_sig_sub ers_rx_sig_sub_props #(.NUM_SLOTS(NUM_SLOTS)) u_props (
    .mclk(mclk), .sys_rst(sys_rst), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .condBeat(condBeat),
    .rxSerialOut(rxSerialOut));

//--- test/ers_term_sink.sv
`timescale 1ns/10ps
module ers_term_sink (
    input  wire logic                  mclk,
    input  wire ers_pkg::ers_beat_type rxBeat,
    output ers_pkg::ers_beat_type      lastBeat
);
    import ers_pkg::*;
    // holds only the newest beat, so the bench checks one beat at a time
    always_ff @(posedge mclk) begin
        if (rxBeat.valid) begin
            lastBeat <= rxBeat;
        end
    end
endmodule

//--- test/test_ers_rx_sig_sub.sv
`timescale 1ns/10ps
module test_ers_rx_sig_sub;
    import ers_pkg::*;
    logic         mclk = 1'b0;
    logic         sysRst = 1'b1;
    logic         wbCyc = 1'b0;
    logic         wbStb = 1'b0;
    logic         wbWe = 1'b0;
    logic [9:0]   wbAdr = '0;
    logic [3:0]   wbSel = '0;
    logic [31:0]  wbDatIn = '0;
    logic [31:0]  wbDatOut;
    logic         wbAck;
    ers_beat_type inBeat = '0;
    ers_beat_type outBeat;
    ers_beat_type seenBeat;
    logic [31:0]  rd;
    logic [7:0]   expSig;
    int           nFail = 0;
    int           checked = 0;

    ers_rx_sig_sub uut (.mclk(mclk), .sys_rst(sysRst), .wb_cyc_i(wbCyc), .wb_stb_i(wbStb),
        .wb_we_i(wbWe), .wb_adr_i(wbAdr), .wb_sel_i(wbSel), .wb_dat_i(wbDatIn),
        .wb_dat_o(wbDatOut), .wb_ack_o(wbAck), .condBeat(inBeat), .rxSerialOut(outBeat));
    ers_term_sink sink (.mclk(mclk), .rxBeat(outBeat), .lastBeat(seenBeat));

    initial begin
        forever #2.5 mclk = ~mclk;
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            nFail++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic reportAndStop();
        $display("checks=%0d mismatches=%0d", checked, nFail);
        if (nFail == 0 && checked > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    // values read before the edge's updates land are the sampled ones
    task automatic wbCycle(input logic we, input logic [7:0] idx, input logic [7:0] wd,
                           input logic [3:0] sel, output logic [31:0] rdv);
        @(posedge mclk);
        wbCyc <= 1'b1;
        wbStb <= 1'b1;
        wbWe <= we;
        wbAdr <= {idx, 2'b00};
        wbSel <= sel;
        wbDatIn <= {24'h0, wd};
        // no cycle count assumed; only the watchdog ends a lost answer
        do begin
            @(posedge mclk);
        end while (wbAck !== 1'b1);
        rdv = wbDatOut;
        wbCyc <= 1'b0;
        wbStb <= 1'b0;
    endtask

    task automatic sendBeat(input logic [3:0] fr, input logic [4:0] sl, input logic [7:0] d,
                            input logic [7:0] exp);
        @(posedge mclk);
        inBeat <= '{1'b1, fr, sl, d};
        @(posedge mclk);
        inBeat.valid <= 1'b0;
        repeat (3) @(posedge mclk);
        #1;
        check({14'h0, seenBeat}, {14'h0, 1'b1, fr, sl, exp});
    endtask

    function automatic logic [3:0] subNib(input logic [1:0] m, input logic [3:0] s);
        case (m)
            2'b00: subNib = 4'hf;
            2'b01: subNib = {4{s[3]}};
            2'b10: subNib = {s[3], s[3], s[2], s[2]};
            default: subNib = s;
        endcase
    endfunction

    initial begin
        repeat (3) @(posedge mclk);
        sysRst <= 1'b0;
        wbCycle(1'b0, 8'ha5, 8'h00, 4'h1, rd);
        check(rd, 32'h0);
        wbCycle(1'b1, 8'h83, 8'hf6, 4'h1, rd);
        wbCycle(1'b0, 8'h83, 8'h00, 4'h1, rd);
        check(rd, 32'hf6);
        wbCycle(1'b1, 8'h93, 8'h09, 4'h1, rd);
        wbCycle(1'b1, 8'ha4, 8'h4c, 4'h0, rd);
        wbCycle(1'b0, 8'ha4, 8'h00, 4'h1, rd);
        check(rd, 32'h0);
        wbCycle(1'b0, 8'h10, 8'h00, 4'h1, rd);
        check(rd, 32'h0);
        wbCycle(1'b1, 8'ha3, 8'h0c, 4'h1, rd);
        sendBeat(4'h3, 5'h10, 8'h5a, 8'h5a);
        for (int m = 0; m < 4; m++) begin
            wbCycle(1'b1, 8'ha3, 8'h40 | 8'(m << 2), 4'h1, rd);
            wbCycle(1'b1, 8'hb3, 8'h40 | 8'(m << 2), 4'h1, rd);
            expSig = {subNib(2'(m), 4'h6), subNib(2'(m), 4'h9)};
            sendBeat(4'h3, 5'h10, 8'h00, expSig);
        end
        sendBeat(4'h4, 5'h10, 8'h00, 8'h00);
        // arm channels 0 and 16 so a frame 0 substitution would show
        wbCycle(1'b1, 8'ha0, 8'h40, 4'h1, rd);
        wbCycle(1'b1, 8'hb0, 8'h40, 4'h1, rd);
        sendBeat(4'h0, 5'h10, 8'h00, 8'h00);
        sendBeat(4'h3, 5'h0f, 8'h00, 8'h00);
        sendBeat(4'h3, 5'h10, 8'ha5, 8'h69);
        // status is read-only, this write must leave it alone
        wbCycle(1'b1, 8'hc0, 8'h55, 4'h1, rd);
        wbCycle(1'b0, 8'hc0, 8'h00, 4'h1, rd);
        check(rd, 32'ha3);
        reportAndStop();
    end

    initial begin
        #8000;
        nFail++;
        reportAndStop();
    end
endmodule
